// ### inc/opp_pkg.sv
// Contract
// - enter mode: supply raised, reset held low
// - page latch: ce high, strobe high, oe low
// - four bytes latched, then 0.1 ms pulse
// - verify page with ce and oe low
// - retry write and verify, ten times most
// - byte write: 0.1 ms strobe, ce low
// - verify byte by lowering oe after pulse
// - program only 0000H through EFFFH
// - read: reset low, address, read, sample
package opp_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int PAGE_BYTES = 4;
  localparam int MAX_TRIES = 10;
  localparam logic [16:0] ADDR_LAST = 17'h0_EFFF;
  localparam int CLK_MHZ = 200;
  localparam int PULSE_US = 100;
  localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
  localparam int SETTLE_CYC = 4;
  localparam int SETUP_CYC = 8;
  localparam logic [1:0] CMD_READ = 2'h0;
  localparam logic [1:0] CMD_BYTE = 2'h1;
  localparam logic [1:0] CMD_PAGE = 2'h2;
  typedef enum logic [7:0] {
    S_IDLE  = 8'b0000_0001,
    S_SETUP = 8'b0000_0010,
    S_LATCH = 8'b0000_0100,
    S_PULSE = 8'b0000_1000,
    S_VER   = 8'b0001_0000,
    S_READ  = 8'b0010_0000,
    S_GAP   = 8'b0100_0000,
    S_DONE  = 8'b1000_0000
  } opp_state_e;
endpackage

// ### rtl/opp_timer.sv
`timescale 1ns/100ps
module opp_timer
  import opp_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic start,
  input wire logic [W-1:0] load,
  output logic busy
);
  logic [W-1:0] cnt_r;
  assign busy = (cnt_r != '0);
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      cnt_r <= '0;
    end else if (CE) begin
      if (start) cnt_r <= load;
      else if (busy) cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

// ### rtl/opp_programmer.sv
`timescale 1ns/100ps
module opp_programmer
  import opp_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic REQ_VALID,
  input wire logic [1:0] REQ_CMD,
  input wire logic [ADDR_W-1:0] REQ_ADDR,
  input wire logic [DATA_W*PAGE_BYTES-1:0] REQ_DATA,
  output logic REQ_READY,
  output logic DONE,
  output logic FAIL,
  output logic RANGE_ERR,
  output logic [DATA_W-1:0] RD_DATA,
  output logic PROG_MODE,
  output logic HIGH_VPP,
  output logic RESET_N_OUT,
  output logic CHIP_ENABLE_N,
  output logic OUTPUT_ENABLE_N,
  output logic PROGRAM_STROBE_N,
  output logic [ADDR_W-1:0] PROM_ADDRESS_BUS,
  output logic [DATA_W-1:0] PROM_DATA_O,
  output logic PROM_DATA_OE,
  input wire logic [DATA_W-1:0] PROM_DATA_I
);
  localparam int TW = $clog2(PULSE_CYCLES + 1);
  opp_state_e st_r, st_nxt;
  logic [DATA_W-1:0] din_s1_r, din_s2_r;
  logic [1:0] cmd_r, idx_r;
  logic [3:0] tries_r;
  logic [ADDR_W-1:0] base_r;
  logic [DATA_W*PAGE_BYTES-1:0] data_r;
  logic bad_r, t_start, t_busy;
  logic [TW-1:0] t_load;

  function automatic logic [DATA_W-1:0] byte_of(input logic [DATA_W*PAGE_BYTES-1:0] d, input logic [1:0] i);
    byte_of = d[i*DATA_W +: DATA_W];
  endfunction

  opp_timer #(.W(TW)) u_tmr (
    .CLK(CLK), .RSTN(RSTN), .CE(CE), .start(t_start), .load(t_load), .busy(t_busy)
  );

  wire [ADDR_W-1:0] cur_addr = base_r | ADDR_W'(idx_r);
  wire [DATA_W-1:0] want = byte_of(data_r, idx_r);
  wire mismatch = (din_s2_r != want);
  wire last_idx = (cmd_r != CMD_PAGE) || (idx_r == 2'(PAGE_BYTES - 1));
  // page request must start aligned and stay inside user space
  wire req_range_bad = (REQ_CMD != CMD_READ) &&
    ((REQ_ADDR > ADDR_LAST) || (REQ_CMD == CMD_PAGE && REQ_ADDR[1:0] != 2'h0));
  // a request counts only while ready is shown, so the first idle cycle after reset takes nothing
  wire take = (st_r == S_IDLE) && REQ_READY && REQ_VALID && !req_range_bad;

  always_comb begin
    st_nxt = st_r;
    t_start = 1'b0;
    t_load = TW'(SETTLE_CYC);
    unique case (st_r)
      S_IDLE: if (take) begin
        st_nxt = S_SETUP;
        t_start = 1'b1;
        t_load = TW'(SETUP_CYC);
      end
      S_SETUP: if (!t_busy) begin
        st_nxt = (cmd_r == CMD_READ) ? S_READ : (cmd_r == CMD_PAGE) ? S_LATCH : S_PULSE;
        t_start = 1'b1;
        // a state lasts one cycle past its load, so the pulse loads one less
        t_load = (cmd_r == CMD_BYTE) ? TW'(PULSE_CYCLES - 1) : TW'(SETTLE_CYC);
      end
      S_LATCH: if (!t_busy) begin
        t_start = 1'b1;
        st_nxt = last_idx ? S_PULSE : S_LATCH;
        t_load = last_idx ? TW'(PULSE_CYCLES - 1) : TW'(SETTLE_CYC);
      end
      S_PULSE: if (!t_busy) begin
        st_nxt = S_GAP;
        t_start = 1'b1;
      end
      S_GAP: if (!t_busy) begin
        st_nxt = S_VER;
        t_start = 1'b1;
        t_load = TW'(SETTLE_CYC + 2);
      end
      S_VER: if (!t_busy) begin
        if (bad_r || mismatch) begin
          st_nxt = (tries_r >= 4'(MAX_TRIES)) ? S_DONE : S_SETUP;
        end else if (!last_idx) begin
          st_nxt = S_VER;
        end else begin
          st_nxt = S_DONE;
        end
        t_start = (st_nxt != S_DONE);
      end
      S_READ: if (!t_busy) st_nxt = S_DONE;
      S_DONE: st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      din_s1_r <= '0;
      din_s2_r <= '0;
    end else if (CE) begin
      din_s1_r <= PROM_DATA_I;
      din_s2_r <= din_s1_r;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      st_r <= S_IDLE;
      cmd_r <= CMD_READ;
      idx_r <= '0;
      tries_r <= '0;
      base_r <= '0;
      data_r <= '0;
      bad_r <= 1'b0;
      DONE <= 1'b0;
      FAIL <= 1'b0;
      RANGE_ERR <= 1'b0;
      RD_DATA <= '0;
    end else if (CE) begin
      st_r <= st_nxt;
      DONE <= (st_r == S_DONE);
      RANGE_ERR <= (st_r == S_IDLE) && REQ_READY && REQ_VALID && req_range_bad;
      // a refused request leaves the last result and failure flag alone
      if (take) begin
        cmd_r <= REQ_CMD;
        base_r <= REQ_ADDR;
        data_r <= REQ_DATA;
        idx_r <= '0;
        tries_r <= '0;
        FAIL <= 1'b0;
      end
      if (st_r == S_SETUP && st_nxt != S_SETUP) begin
        idx_r <= '0;
        bad_r <= 1'b0;
        if (cmd_r != CMD_READ) tries_r <= tries_r + 4'h1;
      end
      if (st_r == S_LATCH && !t_busy && !last_idx) idx_r <= idx_r + 2'h1;
      if (st_r == S_PULSE && !t_busy) idx_r <= '0;
      if (st_r == S_VER && !t_busy) begin
        bad_r <= bad_r | mismatch;
        if (!last_idx) idx_r <= idx_r + 2'h1;
        if ((bad_r || mismatch) && tries_r >= 4'(MAX_TRIES)) FAIL <= 1'b1;
      end
      if (st_r == S_READ && !t_busy) RD_DATA <= din_s2_r;
    end
  end

  // pin levels; strobes decode from state so every mode in the table is reached
  wire busy_s = (st_r != S_IDLE) && (st_r != S_DONE);
  wire ce_n_nxt = !(st_nxt == S_READ || st_nxt == S_VER ||
    (st_nxt == S_PULSE && cmd_r == CMD_BYTE) || (st_nxt == S_GAP && cmd_r == CMD_BYTE));
  wire oe_n_nxt = !(st_nxt == S_READ || st_nxt == S_VER || st_nxt == S_LATCH);
  wire pgm_n_nxt = !(st_nxt == S_PULSE);
  // byte data is held through the gap so it outlasts the strobe's rising edge
  wire drive_nxt = (st_nxt == S_LATCH) ||
    ((st_nxt == S_PULSE || st_nxt == S_GAP) && cmd_r == CMD_BYTE);
  wire [ADDR_W-1:0] addr_nxt = (st_r == S_IDLE) ? REQ_ADDR : cur_addr;

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      REQ_READY <= 1'b0;
      PROG_MODE <= 1'b0;
      HIGH_VPP <= 1'b0;
      RESET_N_OUT <= 1'b1;
      CHIP_ENABLE_N <= 1'b1;
      OUTPUT_ENABLE_N <= 1'b1;
      PROGRAM_STROBE_N <= 1'b1;
      PROM_ADDRESS_BUS <= '0;
      PROM_DATA_O <= '0;
      PROM_DATA_OE <= 1'b0;
    end else if (CE) begin
      REQ_READY <= (st_nxt == S_IDLE);
      PROG_MODE <= (st_nxt != S_IDLE) && (st_nxt != S_DONE);
      HIGH_VPP <= (st_nxt != S_IDLE) && (st_nxt != S_DONE) && (cmd_r != CMD_READ || st_r == S_IDLE ?
        (st_r == S_IDLE ? REQ_CMD != CMD_READ : 1'b1) : 1'b0);
      RESET_N_OUT <= !((st_nxt != S_IDLE) && (st_nxt != S_DONE));
      CHIP_ENABLE_N <= ce_n_nxt;
      OUTPUT_ENABLE_N <= oe_n_nxt;
      PROGRAM_STROBE_N <= pgm_n_nxt;
      PROM_ADDRESS_BUS <= addr_nxt;
      PROM_DATA_O <= byte_of(data_r, st_r == S_IDLE ? 2'h0 : idx_r);
      PROM_DATA_OE <= drive_nxt;
    end
  end

  a_bus_clash: assert property (@(posedge CLK) disable iff (!RSTN)
    PROM_DATA_OE |-> (OUTPUT_ENABLE_N || CHIP_ENABLE_N)) else $error("programmer drives bus during device read");
  a_strobe_width: assert property (@(posedge CLK) disable iff (!RSTN)
    $fell(PROGRAM_STROBE_N) |=> !PROGRAM_STROBE_N [*8]) else $error("program pulse too short");
  a_mode_held: assert property (@(posedge CLK) disable iff (!RSTN)
    !PROGRAM_STROBE_N |-> !RESET_N_OUT && HIGH_VPP) else $error("strobe outside programming mode");
  a_page_pins: assert property (@(posedge CLK) disable iff (!RSTN)
    (!PROGRAM_STROBE_N && CHIP_ENABLE_N) |-> OUTPUT_ENABLE_N) else $error("page pulse with oe low");
  a_tries_cap: assert property (@(posedge CLK) disable iff (!RSTN)
    tries_r <= 4'(MAX_TRIES)) else $error("retry limit exceeded");
  a_fail_done: assert property (@(posedge CLK) disable iff (!RSTN)
    $rose(FAIL) |-> ##[1:3] DONE) else $error("failure without completion");
  a_range_ok: assert property (@(posedge CLK) disable iff (!RSTN)
    !PROGRAM_STROBE_N |-> PROM_ADDRESS_BUS <= ADDR_LAST) else $error("write beyond last address");
  a_verify_pins: assert property (@(posedge CLK) disable iff (!RSTN)
    (st_r == S_VER) |-> !CHIP_ENABLE_N && !OUTPUT_ENABLE_N && PROGRAM_STROBE_N) else $error("bad verify pins");
  c_page: cover property (@(posedge CLK) st_r == S_PULSE && cmd_r == CMD_PAGE);
  c_byte: cover property (@(posedge CLK) st_r == S_PULSE && cmd_r == CMD_BYTE);
  c_retry: cover property (@(posedge CLK) st_r == S_VER && st_nxt == S_SETUP);
  c_read: cover property (@(posedge CLK) DONE && cmd_r == CMD_READ);
endmodule

// ### dv/opp_prom_model.sv
`timescale 1ns/100ps
module opp_prom_model
  import opp_pkg::*;
(
  input wire logic RESET_N,
  input wire logic PROG_MODE,
  input wire logic HIGH_VPP,
  input wire logic CHIP_ENABLE_N,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic PROGRAM_STROBE_N,
  input wire logic [ADDR_W-1:0] PROM_ADDRESS_BUS,
  input wire logic [DATA_W-1:0] PROM_DATA_O,
  input wire logic PROM_DATA_OE,
  output logic [DATA_W-1:0] PROM_DATA_I
);
  localparam int MEM_BYTES = 61440;
  logic [DATA_W-1:0] mem [0:MEM_BYTES-1];
  logic [DATA_W-1:0] page_q [0:PAGE_BYTES-1];
  logic [ADDR_W-1:0] page_base;
  logic [DATA_W-1:0] last_q;
  int skip_left;
  int writes;
  realtime fall_t;
  realtime last_width;
  wire mode = !RESET_N && PROG_MODE;
  wire drive = mode && !CHIP_ENABLE_N && !OUTPUT_ENABLE_N;
  wire [DATA_W-1:0] rd_q = (PROM_ADDRESS_BUS < MEM_BYTES) ? mem[PROM_ADDRESS_BUS] : 8'hFF;
  // a released bus has no pull, so show the inverse of the last value to expose stale reads
  assign PROM_DATA_I = drive ? rd_q : (PROM_DATA_OE ? PROM_DATA_O : ~last_q);
  initial begin
    for (int i = 0; i < MEM_BYTES; i++) mem[i] = 8'hFF;
    last_q = 8'h00;
    skip_left = 0;
    writes = 0;
  end
  always @(*) begin
    if (drive) last_q = rd_q;
    else if (PROM_DATA_OE) last_q = PROM_DATA_O;
  end
  always @(*) begin
    if (mode && CHIP_ENABLE_N && !OUTPUT_ENABLE_N && PROGRAM_STROBE_N) begin
      // the latch takes what stands on the bus, so an undriven bus shows up as wrong data
      page_q[PROM_ADDRESS_BUS[1:0]] = PROM_DATA_I;
      page_base = {PROM_ADDRESS_BUS[ADDR_W-1:2], 2'b00};
    end
  end
  always @(negedge PROGRAM_STROBE_N) fall_t = $realtime;
  // cells only take charge at the end of the pulse; a held-high strobe never writes
  always @(posedge PROGRAM_STROBE_N) begin
    if (mode && HIGH_VPP && OUTPUT_ENABLE_N) begin
      last_width = $realtime - fall_t;
      writes++;
      if (skip_left > 0) skip_left--;
      else if (CHIP_ENABLE_N) begin
        for (int i = 0; i < PAGE_BYTES; i++) mem[page_base + i] &= page_q[i];
      end else mem[PROM_ADDRESS_BUS] &= PROM_DATA_I;
    end
  end
endmodule

// ### dv/test_opp_programmer.sv
`timescale 1ns/100ps
module test_opp_programmer
  import opp_pkg::*;
;
  logic clk = 0, rstn = 0, ce = 1, req_valid = 0;
  logic [1:0] req_cmd = 0;
  logic [16:0] req_addr = 0;
  logic [31:0] req_data = 0;
  logic req_ready, done, fail, range_err, prog_mode, high_vpp, reset_n_out, ce_n, oe_n, pgm_n, data_oe;
  logic [7:0] rd_data, data_o, data_i;
  logic [16:0] addr_bus;
  int err_count = 0;
  int compares = 0;
  int w0;
  opp_programmer #(.PULSE_CYCLES(16)) u_opp_programmer (.CLK(clk), .RSTN(rstn), .CE(ce),
    .REQ_VALID(req_valid), .REQ_CMD(req_cmd), .REQ_ADDR(req_addr), .REQ_DATA(req_data),
    .REQ_READY(req_ready), .DONE(done), .FAIL(fail), .RANGE_ERR(range_err), .RD_DATA(rd_data),
    .PROG_MODE(prog_mode), .HIGH_VPP(high_vpp), .RESET_N_OUT(reset_n_out), .CHIP_ENABLE_N(ce_n),
    .OUTPUT_ENABLE_N(oe_n), .PROGRAM_STROBE_N(pgm_n), .PROM_ADDRESS_BUS(addr_bus),
    .PROM_DATA_O(data_o), .PROM_DATA_OE(data_oe), .PROM_DATA_I(data_i));
  opp_prom_model u_opp_prom_model (.RESET_N(reset_n_out), .PROG_MODE(prog_mode), .HIGH_VPP(high_vpp),
    .CHIP_ENABLE_N(ce_n), .OUTPUT_ENABLE_N(oe_n), .PROGRAM_STROBE_N(pgm_n), .PROM_ADDRESS_BUS(addr_bus),
    .PROM_DATA_O(data_o), .PROM_DATA_OE(data_oe), .PROM_DATA_I(data_i));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // request is held until the edge that sees ready high, then released
  task automatic run_op(input logic [1:0] cmd, input logic [16:0] addr, input logic [31:0] data, input logic bad);
    int n;
    n = 0;
    // always let one edge pass, so a refused request is never re-raised in the same step
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (req_ready !== 1'b1 && n < 100);
    req_cmd = cmd;
    req_addr = addr;
    req_data = data;
    req_valid = 1'b1;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    check(range_err, bad);
    n = 0;
    while (!bad && done !== 1'b1 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (!bad) check(done, 1'b1);
  endtask
  task automatic t_byte;
    u_opp_prom_model.skip_left = 1;
    w0 = u_opp_prom_model.writes;
    run_op(CMD_BYTE, 17'h0_0010, 32'h0000_005A, 1'b0);
    check(fail, 1'b0);
    check(u_opp_prom_model.writes - w0, 2);
    check(int'(u_opp_prom_model.last_width * 10), 800);
    run_op(CMD_READ, 17'h0_0010, 32'h0000_0000, 1'b0);
    check(rd_data, 8'h5A);
  endtask
  // a low enable must freeze the walk, pins included, and the read still returns the byte
  task automatic t_freeze;
    fork
      run_op(CMD_READ, 17'h0_0010, 32'h0000_0000, 1'b0);
      begin
        repeat (6) @(posedge clk);
        #1;
        ce = 1'b0;
        w0 = ce_n;
        repeat (20) @(posedge clk);
        #1;
        check(ce_n, w0);
        ce = 1'b1;
      end
    join
    check(rd_data, 8'h5A);
  endtask
  task automatic t_page;
    w0 = u_opp_prom_model.writes;
    run_op(CMD_PAGE, 17'h0_EFFC, 32'h4433_2211, 1'b0);
    check(u_opp_prom_model.writes - w0, 1);
    for (int i = 0; i < 4; i++) begin
      run_op(CMD_READ, 17'h0_EFFC + i, 32'h0000_0000, 1'b0);
      check(rd_data, 8'h11 * (i + 1));
    end
  endtask
  task automatic t_refuse;
    w0 = u_opp_prom_model.writes;
    run_op(CMD_BYTE, 17'h0_F000, 32'h0000_0000, 1'b1);
    run_op(CMD_PAGE, 17'h0_0011, 32'h0000_0000, 1'b1);
    check(u_opp_prom_model.writes - w0, 0);
    run_op(CMD_READ, 17'h0_0020, 32'h0000_0000, 1'b0);
    check(rd_data, 8'hFF);
  endtask
  task automatic t_fail;
    u_opp_prom_model.skip_left = 10;
    w0 = u_opp_prom_model.writes;
    run_op(CMD_BYTE, 17'h0_0030, 32'h0000_00A5, 1'b0);
    check(fail, 1'b1);
    check(u_opp_prom_model.writes - w0, 10);
    run_op(CMD_READ, 17'h0_0030, 32'h0000_0000, 1'b0);
    check({fail, rd_data}, 9'h0FF);
  endtask
  initial begin
    #400000;
    err_count++;
    tally_and_finish;
  end
  initial begin
    repeat (5) @(posedge clk);
    #1;
    check({req_ready, reset_n_out, pgm_n, ce_n}, 4'h7);
    rstn = 1'b1;
    t_byte();
    t_freeze();
    t_page();
    t_refuse();
    t_fail();
    tally_and_finish;
  end
endmodule
